// ### pkg/sarpr_map.vh
/*
 * Constants for the parallel readout block of the 18-bit converter:
 * timing figures, derived cycle counts, data width, FIFO depth and code limits.
 * Assumes a 125 MHz system clock; included by bare name.
 */
`ifndef SARPR_MAP_VH
`define SARPR_MAP_VH

// ****************************************************************
// timing
// ****************************************************************
`define SARPR_CLK_PERIOD_NS   8
`define SARPR_CONV_TIME_NS    650
// longest time rounds down
`define SARPR_CONV_CYCLES     (`SARPR_CONV_TIME_NS / `SARPR_CLK_PERIOD_NS)
`define SARPR_ACQ_TIME_NS     320
`define SARPR_ACQ_CYCLES      ((`SARPR_ACQ_TIME_NS + `SARPR_CLK_PERIOD_NS - 1) / `SARPR_CLK_PERIOD_NS)
`define SARPR_TRIM_CONVS      3

// ****************************************************************
// data layout
// ****************************************************************
`define SARPR_DATA_W          18
`define SARPR_FIFO_DEPTH      16
`define SARPR_CODE_POS_MAX    18'h1_FFFF
`define SARPR_CODE_ZERO       18'h0_0000
`define SARPR_CODE_NEG_ONE    18'h3_FFFF
`define SARPR_CODE_NEG_MAX    18'h2_0000
`define SARPR_ALL_ONES        18'h3_FFFF

`endif

// ### src/sarpr_fifo.v
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset; read data
 * come out of a register.
 */
module sarpr_fifo #(
	parameter WIDTH = 18,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             i_clk,
	input  wire             i_rstn,
	// synchronous flush
	input  wire             i_flush,
	// fill side
	input  wire             i_wr_valid,
	output wire             o_wr_ready,
	input  wire [WIDTH-1:0] i_wr_data,
	// drain side
	output wire             o_rd_valid,
	input  wire             i_rd_ready,
	output reg  [WIDTH-1:0] o_rd_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_ptr_q;
	reg [AW:0]      rd_ptr_q;
	reg             out_vld_q;
	wire [AW:0]     count;
	wire [AW:0]     occ;
	wire            empty;
	wire            full;
	wire            push;
	wire            load;

	assign count      = wr_ptr_q - rd_ptr_q;
	assign empty      = (count == {(AW+1){1'b0}});
	// the output register is one of the DEPTH words, not an extra one
	assign occ        = count + {{AW{1'b0}}, out_vld_q};
	assign full       = (occ >= DEPTH[AW:0]);
	assign o_wr_ready = ~full;
	assign push       = i_wr_valid & ~full;
	// output register refills when empty or being taken
	assign load       = ~empty & (~out_vld_q | i_rd_ready);
	assign o_rd_valid = out_vld_q;

	always @(posedge i_clk) begin
		if (push)
			mem[wr_ptr_q[AW-1:0]] <= i_wr_data;
	end

	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr_q  <= {(AW+1){1'b0}};
			rd_ptr_q  <= {(AW+1){1'b0}};
			out_vld_q <= 1'b0;
			o_rd_data <= {WIDTH{1'b0}};
		end else if (i_flush) begin
			wr_ptr_q  <= {(AW+1){1'b0}};
			rd_ptr_q  <= {(AW+1){1'b0}};
			out_vld_q <= 1'b0;
			o_rd_data <= {WIDTH{1'b0}};
		end else begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (load) begin
				o_rd_data <= mem[rd_ptr_q[AW-1:0]];
				rd_ptr_q  <= rd_ptr_q + 1'b1;
				out_vld_q <= 1'b1;
			end else if (i_rd_ready) begin
				out_vld_q <= 1'b0;
			end
		end
	end

endmodule // sarpr_fifo

// ### src/sarpr_readout.v
/*
 * Digital side of an 18-bit successive-approximation converter:
 * conversion start, hold and busy timing from the internal clock,
 * result latch, 18-bit, byte and two-bit readout lanes, trim conversions after
 * reset and the strobe-driven self-clearing reset.
 * Assumes the strobes arrive asynchronously from a host and that the
 * analog core delivers its code on i_core_code with i_core_valid.
 */
`include "sarpr_map.vh"

// How it works
// - conversion timing comes from the internal clock only; no external clock.
// - convert_start_n falling edge with select low ends sampling and enters hold, capturing input.
// - busy rises right after convert_start_n falls with select low, falls when conversion ends.
// - sampling restarts on busy fall (select tied low) or select fall.
// - result_bus driven only while select and read both low.
// - result is an 18-bit two's complement style code, 20000 to 1FFFF.
// - both lane selects low: all eighteen bits on the full bus.
// - width select high, byte low: bits 1..0 on pins 3..2, others one.
// - byte high, width low: bits 9..2 on pins 17..10, lower pins one.
// - both high: bits 1..0 on pins 11..10, every other pin one.
// - lanes follow the selects whether read toggles or stays low.
// - after reset the first three conversions load trim; results invalid.
// - start edge during a conversion with select low triggers a reset.
// - select falling during a conversion triggers a reset.
// - reset clears latches to zero, drops busy, starts sampling.
// - a conversion keeps busy high for about 650 ns.
module sarpr_readout #(
	parameter DATA_W      = `SARPR_DATA_W,
	parameter CONV_CYCLES = `SARPR_CONV_CYCLES,
	parameter TRIM_CONVS  = `SARPR_TRIM_CONVS,
	parameter FIFO_DEPTH  = `SARPR_FIFO_DEPTH
) (
	// clock and reset
	input  wire              i_clk,
	input  wire              i_rstn,
	// host strobes, asynchronous
	input  wire              i_convert_start_n,
	input  wire              i_chip_select_n,
	input  wire              i_read_strobe_n,
	input  wire              i_bus_width_select,
	input  wire              i_byte_lane_select,
	// analog core code, same clock
	input  wire [DATA_W-1:0] i_core_code,
	input  wire              i_core_valid,
	output wire              o_core_ready,
	// converter status
	output wire              o_busy,
	output reg               o_hold,
	output reg               o_trim_active,
	// result bus, three-state as separate signals
	output reg  [DATA_W-1:0] o_result_bus,
	output reg  [DATA_W-1:0] o_result_bus_oe
);

	// ****************************************************************
	// state
	// ****************************************************************
	localparam [1:0] ST_SAMPLE = 2'b00;
	localparam [1:0] ST_CONV   = 2'b01;
	localparam [1:0] ST_WAIT   = 2'b10;
	localparam [1:0] ST_IDLE   = 2'b11;

	localparam CNT_W = 8;
	localparam [CNT_W-1:0] CONV_LAST = CONV_CYCLES[CNT_W-1:0] - 1'b1;
	localparam [1:0] TRIM_N = TRIM_CONVS[1:0];

	reg [2:0]        cst_sync_q;
	reg [2:0]        cs_sync_q;
	reg [2:0]        rd_sync_q;
	reg [2:0]        bw_sync_q;
	reg [2:0]        by_sync_q;
	reg              cst_q;
	reg              cs_q;
	reg              rd_q;
	reg              bw_q;
	reg              by_q;
	reg [1:0]        state_q;
	reg [CNT_W-1:0]  cnt_q;
	reg              busy_q;
	reg [1:0]        trim_q;
	reg [DATA_W-1:0] latch_q;
	reg              flush_q;
	reg [1:0]        state_d;
	reg [CNT_W-1:0]  cnt_d;
	reg              busy_d;
	reg              hold_d;
	reg [1:0]        trim_d;
	reg              trim_act_d;
	reg [DATA_W-1:0] latch_d;
	reg              flush_d;
	reg [DATA_W-1:0] bus_d;
	reg [DATA_W-1:0] oe_d;

	wire             cst_fall;
	wire             cs_fall;
	wire             conv_done;
	wire             self_reset;
	wire             fifo_vld;
	wire [DATA_W-1:0] fifo_data;
	wire             fifo_take;

	// a change counts once the second and third stages agree
	function filt;
		input [2:0] s;
		input       prev;
		begin
			filt = (s[1] == s[2]) ? s[2] : prev;
		end
	endfunction

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cst_sync_q <= 3'b111;
			cs_sync_q  <= 3'b111;
			rd_sync_q  <= 3'b111;
			bw_sync_q  <= 3'b000;
			by_sync_q  <= 3'b000;
			cst_q      <= 1'b1;
			cs_q       <= 1'b1;
			rd_q       <= 1'b1;
			bw_q       <= 1'b0;
			by_q       <= 1'b0;
		end else begin
			cst_sync_q <= {cst_sync_q[1:0], i_convert_start_n};
			cs_sync_q  <= {cs_sync_q[1:0], i_chip_select_n};
			rd_sync_q  <= {rd_sync_q[1:0], i_read_strobe_n};
			bw_sync_q  <= {bw_sync_q[1:0], i_bus_width_select};
			by_sync_q  <= {by_sync_q[1:0], i_byte_lane_select};
			cst_q      <= filt(cst_sync_q, cst_q);
			cs_q       <= filt(cs_sync_q, cs_q);
			rd_q       <= filt(rd_sync_q, rd_q);
			bw_q       <= filt(bw_sync_q, bw_q);
			by_q       <= filt(by_sync_q, by_q);
		end
	end

	// ****************************************************************
	// strobe edges
	// ****************************************************************
	// a 20 ns start pulse spans at least two samples of the filter
	assign cst_fall   = cst_q & ~filt(cst_sync_q, cst_q) & ~cs_q;
	assign cs_fall    = cs_q & ~filt(cs_sync_q, cs_q);
	assign self_reset = busy_q & (cst_fall | cs_fall);
	assign conv_done  = (state_q == ST_WAIT) & fifo_vld;

	// ****************************************************************
	// conversion sequencer
	// ****************************************************************
	// next state apart from the registers, so every path holds its value
	always @* begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		busy_d     = busy_q;
		hold_d     = o_hold;
		trim_d     = trim_q;
		trim_act_d = o_trim_active;
		latch_d    = latch_q;
		flush_d    = 1'b0;
		if (self_reset) begin
			// a reset, not a new conversion
			state_d = ST_SAMPLE;
			busy_d  = 1'b0;
			hold_d  = 1'b0;
			latch_d = `SARPR_CODE_ZERO;
			cnt_d   = {CNT_W{1'b0}};
			flush_d = 1'b1;
		end else begin
			case (state_q)
			ST_SAMPLE, ST_IDLE: begin
				if (cst_fall) begin
					state_d = ST_CONV;
					hold_d  = 1'b1;
					busy_d  = 1'b1;
					cnt_d   = {CNT_W{1'b0}};
				end else if (state_q == ST_IDLE && cs_fall) begin
					// select falling with busy low restarts sampling
					state_d = ST_SAMPLE;
				end
			end
			ST_CONV: begin
				if (cnt_q == CONV_LAST) begin
					state_d = ST_WAIT;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			ST_WAIT: begin
				if (conv_done) begin
					busy_d  = 1'b0;
					hold_d  = 1'b0;
					state_d = cs_q ? ST_IDLE : ST_SAMPLE;
					if (trim_q != TRIM_N) begin
						// trim conversions leave the latch untouched
						trim_d = trim_q + 1'b1;
						if (trim_q == TRIM_N - 2'd1)
							trim_act_d = 1'b0;
					end else begin
						latch_d = fifo_data;
					end
				end
			end
			default: begin
				state_d = ST_SAMPLE;
			end
			endcase
		end
	end

	// the sequencer runs on the internal clock only
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q       <= ST_SAMPLE;
			cnt_q         <= {CNT_W{1'b0}};
			busy_q        <= 1'b0;
			o_hold        <= 1'b0;
			trim_q        <= 2'b00;
			o_trim_active <= 1'b1;
			latch_q       <= `SARPR_CODE_ZERO;
			flush_q       <= 1'b0;
		end else begin
			state_q       <= state_d;
			cnt_q         <= cnt_d;
			busy_q        <= busy_d;
			o_hold        <= hold_d;
			trim_q        <= trim_d;
			o_trim_active <= trim_act_d;
			latch_q       <= latch_d;
			flush_q       <= flush_d;
		end
	end

	assign o_busy    = busy_q;
	assign fifo_take = conv_done;

	// ****************************************************************
	// core code buffer
	// ****************************************************************
	// core may deliver early; the buffer absorbs it until the slot ends
	sarpr_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_flush    (flush_q),
		.i_wr_valid (i_core_valid),
		.o_wr_ready (o_core_ready),
		.i_wr_data  (i_core_code),
		.o_rd_valid (fifo_vld),
		.i_rd_ready (fifo_take),
		.o_rd_data  (fifo_data)
	);

	// ****************************************************************
	// readout lanes
	// ****************************************************************
	function [DATA_W-1:0] lanes;
		input [DATA_W-1:0] d;
		input              bw;
		input              by;
		begin
			lanes = `SARPR_ALL_ONES;
			case ({by, bw})
			2'b00: lanes = d;
			2'b01: lanes[3:2] = d[1:0];
			2'b10: lanes[17:10] = d[9:2];
			2'b11: lanes[11:10] = d[1:0];
			default: lanes = `SARPR_ALL_ONES;
			endcase
		end
	endfunction

	// lanes follow the selects every cycle, so held read works
	always @* begin
		bus_d = lanes(latch_q, bw_q, by_q);
		oe_d  = {DATA_W{~cs_q & ~rd_q}};
	end

	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_result_bus    <= {DATA_W{1'b0}};
			o_result_bus_oe <= {DATA_W{1'b0}};
		end else begin
			o_result_bus    <= bus_d;
			o_result_bus_oe <= oe_d;
		end
	end

endmodule // sarpr_readout

// ### testbench/sarpr_chk_sva.sv
/* assertion checker for the parallel readout block
   sees only the top ports; strobes are filtered inside, hence the 6-cycle windows */
module sarpr_chk #(
	parameter DATA_W = 18
) (
	input wire logic              i_clk,
	input wire logic              i_rstn,
	input wire logic              i_convert_start_n,
	input wire logic              i_chip_select_n,
	input wire logic              i_read_strobe_n,
	input wire logic              i_bus_width_select,
	input wire logic              i_byte_lane_select,
	input wire logic              o_busy,
	input wire logic              o_hold,
	input wire logic              o_trim_active,
	input wire logic [DATA_W-1:0] o_result_bus,
	input wire logic [DATA_W-1:0] o_result_bus_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// ****************************************************************
	// assertions
	// ****************************************************************
	a_oe_off_idle: assert property ((i_chip_select_n | i_read_strobe_n)[*6] |-> o_result_bus_oe == '0)
		else $error("result bus driven without both strobes");
	a_oe_all_bits: assert property (o_result_bus_oe == '0 || o_result_bus_oe == '1)
		else $error("result bus partly driven");
	a_lane_low_two: assert property ((i_bus_width_select & ~i_byte_lane_select)[*6] |->
		o_result_bus[17:4] == '1 && o_result_bus[1:0] == 2'b11) else $error("low lane fill");
	a_lane_mid_byte: assert property ((~i_bus_width_select & i_byte_lane_select)[*6] |->
		o_result_bus[9:0] == '1) else $error("middle byte fill");
	a_lane_top_two: assert property ((i_bus_width_select & i_byte_lane_select)[*6] |->
		o_result_bus[17:12] == '1 && o_result_bus[9:0] == '1) else $error("top lane fill");
	a_start_self_reset: assert property (o_busy && $fell(i_convert_start_n) && !i_chip_select_n
		|-> ##[1:7] !o_busy) else $error("start during conversion kept busy");
	a_select_self_reset: assert property (o_busy && $fell(i_chip_select_n) |-> ##[1:7] !o_busy)
		else $error("select during conversion kept busy");
	a_busy_holds: assert property (o_busy |-> o_hold) else $error("busy outside hold");
	a_busy_cause: assert property ($rose(o_busy) |-> !$past(i_convert_start_n, 3) ||
		!$past(i_convert_start_n, 4) || !$past(i_convert_start_n, 5)) else $error("busy without start");
	a_sample_restart: assert property ((!i_chip_select_n)[*6] ##0 $fell(o_busy) |-> !o_hold)
		else $error("sampling did not restart");
	a_trim_end: assert property ($fell(o_trim_active) |-> $fell(o_busy))
		else $error("trim ended outside a completion");
endmodule // sarpr_chk

bind sarpr_readout sarpr_chk #(.DATA_W(DATA_W)) sarpr_chk_inst (
	.i_clk(i_clk), .i_rstn(i_rstn), .i_convert_start_n(i_convert_start_n),
	.i_chip_select_n(i_chip_select_n), .i_read_strobe_n(i_read_strobe_n),
	.i_bus_width_select(i_bus_width_select), .i_byte_lane_select(i_byte_lane_select),
	.o_busy(o_busy), .o_hold(o_hold), .o_trim_active(o_trim_active),
	.o_result_bus(o_result_bus), .o_result_bus_oe(o_result_bus_oe)
);

// ### testbench/sarpr_host.sv
/* host model driving start, select, read and lane strobes
   assumes one caller at a time; changes land 1 ns after a rising edge */
module sarpr_host (
	// clock
	input  wire logic i_clk,
	// strobes to the converter
	output logic      o_convert_start_n,
	output logic      o_chip_select_n,
	output logic      o_read_strobe_n,
	output logic      o_bus_width_select,
	output logic      o_byte_lane_select,
	// one-cycle mark: result settled, sample now
	output logic      o_sample
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{o_convert_start_n, o_chip_select_n, o_read_strobe_n} = 3'b111;
		{o_bus_width_select, o_byte_lane_select, o_sample} = 3'b000;
	end
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// acquisition gap before the edge also keeps reads out of the quiet zone
	task automatic start(input logic cs_after, input int acq);
		step(acq);
		o_chip_select_n = 1'b0;
		step(1);
		o_convert_start_n = 1'b0;
		step(3);
		o_convert_start_n = 1'b1;
		o_chip_select_n = cs_after;
	endtask
	// held keeps the read strobe low into the next lane
	task automatic read(input logic by, input logic bw, input logic held);
		o_byte_lane_select = by;
		o_bus_width_select = bw;
		o_chip_select_n = 1'b0;
		o_read_strobe_n = 1'b0;
		step(8);
		o_sample = 1'b1;
		step(1);
		o_sample = 1'b0;
		o_read_strobe_n = ~held;
		o_chip_select_n = ~held;
	endtask
	// lane selects wander while no read is open; only reads pin them down
	task automatic idle(input logic [1:0] sel);
		o_bus_width_select = sel[0];
		o_byte_lane_select = sel[1];
	endtask
endmodule // sarpr_host

// ### testbench/tb.sv
/* self-checking bench for the parallel readout block
   assumes the host model and the bound checker; short conversion count */
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int CONV = 40;
	localparam logic [17:0] EDGE_CODES [4] = '{18'h1_ffff, 18'h0_0000, 18'h3_ffff, 18'h2_0000};
	logic        i_clk = 1'b0;
	logic        i_rstn = 1'b0;
	logic [17:0] i_core_code = 18'h0_0000;
	logic        i_core_valid = 1'b0;
	wire         cst_n, cs_n, rd_n, bw, by, smp, core_ready, busy, hold, trim;
	wire  [17:0] bus, bus_oe;
	int          bad_count = 0;
	int          total_checks = 0;
	logic [31:0] lfsr_q = 32'd97672;
	logic [17:0] exp_q [$];
	logic [17:0] fill_q [$];
	always #4 i_clk = ~i_clk;
	sarpr_host sarpr_host_inst (.i_clk(i_clk), .o_convert_start_n(cst_n), .o_chip_select_n(cs_n),
		.o_read_strobe_n(rd_n), .o_bus_width_select(bw), .o_byte_lane_select(by), .o_sample(smp));
	sarpr_readout #(.CONV_CYCLES(CONV)) sarpr_readout_inst (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_convert_start_n(cst_n), .i_chip_select_n(cs_n), .i_read_strobe_n(rd_n),
		.i_bus_width_select(bw), .i_byte_lane_select(by), .i_core_code(i_core_code),
		.i_core_valid(i_core_valid), .o_core_ready(core_ready), .o_busy(busy), .o_hold(hold),
		.o_trim_active(trim), .o_result_bus(bus), .o_result_bus_oe(bus_oe));
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [17:0] lane(input logic [17:0] d, input logic b, input logic w);
		case ({b, w})
			2'b00: return d;
			2'b01: return {14'h3fff, d[1:0], 2'b11};
			2'b10: return {d[9:2], 10'h3ff};
			default: return {6'h3f, d[1:0], 10'h3ff};
		endcase
	endfunction
	task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wait_busy(input logic val, output int n);
		n = 0;
		while (busy !== val) begin
			sarpr_host_inst.step(1);
			n++;
			if (n > 300) begin
				bad_count++;
				test_done();
			end
		end
	endtask
	// one word into the core buffer unless pre is set, then a full conversion
	task automatic conv(input logic [17:0] c, input logic pre);
		int n;
		sarpr_host_inst.idle(lfsr_q[1:0]);
		lfsr_q = lfsr_next(lfsr_q);
		if (!pre) begin
			i_core_code = c;
			i_core_valid = 1'b1;
			sarpr_host_inst.step(1);
			i_core_valid = 1'b0;
		end
		sarpr_host_inst.start(1'b0, 40);
		wait_busy(1'b1, n);
		wait_busy(1'b0, n);
		check("busy_len", 18'(n >= CONV), 18'h0_0001);
		check("hold", 18'(hold), 18'h0_0000);
	endtask
	always @(posedge i_clk) begin
		if (smp === 1'b1) begin
			check("oe", bus_oe, 18'h3_ffff);
			if (exp_q.size() == 0) begin
				check("queue", 18'h0_0000, 18'h0_0001);
			end else begin
				check("result_bus", bus, exp_q.pop_front());
			end
		end
	end
	// ****************************************************************
	// sequence
	// ****************************************************************
	initial begin
		logic [17:0] c;
		repeat (4) @(posedge i_clk);
		#1 i_rstn = 1'b1;
		check("busy", 18'(busy), 18'h0_0000);
		for (int i = 0; i < 3; i++) begin
			check("trim", 18'(trim), 18'h0_0001);
			conv(18'h1_5a5a, 1'b0);
		end
		check("trim", 18'(trim), 18'h0_0000);
		exp_q.push_back(18'h0_0000);
		sarpr_host_inst.read(1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 6; i++) begin
			c = (i < 4) ? EDGE_CODES[i] : lfsr_q[17:0];
			lfsr_q = lfsr_next(lfsr_q);
			conv(c, 1'b0);
			for (int l = 0; l < 5; l++) begin
				exp_q.push_back(lane(c, l[1], l[0]));
				sarpr_host_inst.read(l[1], l[0], i[0] && l < 4);
			end
		end
		// select falling mid-conversion clears the latch
		sarpr_host_inst.start(1'b1, 40);
		sarpr_host_inst.step(3);
		exp_q.push_back(18'h0_0000);
		sarpr_host_inst.read(1'b0, 1'b0, 1'b0);
		check("busy", 18'(busy), 18'h0_0000);
		// fill the core buffer until it refuses, then drain it
		i_core_valid = 1'b1;
		for (int k = 0; k < 16; k++) begin
			i_core_code = lfsr_q[17:0];
			fill_q.push_back(lfsr_q[17:0]);
			lfsr_q = lfsr_next(lfsr_q);
			check("ready", 18'(core_ready), 18'h0_0001);
			sarpr_host_inst.step(1);
		end
		check("ready", 18'(core_ready), 18'h0_0000);
		i_core_valid = 1'b0;
		for (int k = 0; k < 16; k++) begin
			conv(18'h0_0000, 1'b1);
			exp_q.push_back(fill_q.pop_front());
			sarpr_host_inst.read(1'b0, 1'b0, 1'b0);
		end
		// second start during conversion resets instead of restarting
		conv(lfsr_q[17:0], 1'b0);
		sarpr_host_inst.start(1'b0, 40);
		sarpr_host_inst.start(1'b0, 4);
		sarpr_host_inst.step(5);
		exp_q.push_back(18'h0_0000);
		sarpr_host_inst.read(1'b0, 1'b0, 1'b0);
		check("busy", 18'(busy), 18'h0_0000);
		check("hold", 18'(hold), 18'h0_0000);
		test_done();
	end
endmodule // tb
